// ==== core/cmv_add8.sv ====
`timescale 1ns/1ps
`default_nettype none
module cmv_add8 (
    // Operands
    input wire logic [7:0] a,
    input wire logic [7:0] b,
    input wire logic cin,
    // Sum and flag terms
    output logic [7:0] sum,
    output logic cy,
    output logic ac,
    output logic ov
);
    logic [4:0] lo;
    logic [8:0] full;

    assign lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    assign full = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    assign sum = full[7:0];
    assign cy = full[8];
    assign ac = lo[4];
    // Same-sign operands giving a different-sign sum
    assign ov = (a[7] == b[7]) && (sum[7] != a[7]);
endmodule // cmv_add8
`default_nettype wire

// ==== core/cmv_exec_unit.sv ====
`timescale 1ns/1ps
`default_nettype none
module cmv_exec_unit (
    // Clock, reset, enable
    input wire logic mclk,
    input wire logic rst_b,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Execution status
    output logic [23:0] mem_addr,
    output logic op_done,
    output logic op_illegal
);
    logic [31:0] ctrl_r;
    logic [23:0] opa_r;
    logic [23:0] opb_r;
    logic [23:0] addr_r;
    logic [15:0] psw_r;
    logic [7:0] sav_r;
    logic [14:0] fcode_r;
    logic [19:0] pc_r;
    logic [23:0] res_a_r;
    logic [23:0] res_b_r;
    logic [19:0] tgt_r;
    logic [8:0] info_r;
    logic [23:0] ptr_r [4];
    logic [23:0] mem_addr_r;
    logic done_r;
    logic ill_r;
    logic setup_r;
    logic [31:0] prdata_r;
    logic [31:0] rd_mux;

    function automatic logic fl_apply(input logic [2:0] code, input logic cur, input logic res,
                                      input logic sav);
        logic v;
        v = cur;
        case (code)
            cmv_pkg::FC_CLR: v = 1'b0;
            cmv_pkg::FC_SET: v = 1'b1;
            cmv_pkg::FC_RES, cmv_pkg::FC_PAR, cmv_pkg::FC_OVF: v = res;
            cmv_pkg::FC_REST: v = sav;
            default: v = cur;
        endcase
        return v;
    endfunction

    function automatic logic [1:0] ptr_idx(input logic [3:0] mode, input logic [1:0] bsel);
        logic [1:0] i;
        i = bsel;
        case (mode)
            cmv_pkg::M_PA, cmv_pkg::M_PA_INC, cmv_pkg::M_PA_DEC: i = 2'd0;
            cmv_pkg::M_PB, cmv_pkg::M_PB_INC, cmv_pkg::M_PB_DEC: i = 2'd1;
            cmv_pkg::M_PC: i = 2'd2;
            cmv_pkg::M_PD: i = 2'd3;
            default: i = bsel;
        endcase
        return i;
    endfunction

    // APB handshake: one access phase after a captured setup, wait-free while ce is high and stalled while ce is low
    wire logic cap = psel & ~setup_r;
    wire logic wr = psel & penable & pwrite & pready;
    wire logic hit = (paddr[1:0] == 2'b00) && (paddr <= cmv_pkg::OFS_PTR3);
    assign pready = ce & psel & penable & setup_r;
    assign pslverr = pready & ~hit;
    assign prdata = prdata_r;
    wire logic exec = wr && (paddr == cmv_pkg::OFS_CTRL);

    // Fields of the control word being written
    wire cmv_pkg::cmv_op_t c_op = cmv_pkg::cmv_op_t'(pwdata[cmv_pkg::CF_OP_LSB +: 4]);
    wire cmv_pkg::cmv_mode_t c_mode = cmv_pkg::cmv_mode_t'(pwdata[cmv_pkg::CF_MODE_LSB +: 4]);
    wire cmv_pkg::cmv_class_t c_cls = cmv_pkg::cmv_class_t'(pwdata[cmv_pkg::CF_CLASS_LSB +: 2]);
    wire cmv_pkg::cmv_prefix_t c_pfx = cmv_pkg::cmv_prefix_t'(pwdata[cmv_pkg::CF_PREFIX_LSB +: 4]);
    wire logic [2:0] c_blen = pwdata[cmv_pkg::CF_BLEN_LSB +: 3];
    wire logic [1:0] c_bsel = pwdata[cmv_pkg::CF_BSEL_LSB +: 2];
    wire logic c_dir = pwdata[cmv_pkg::CF_DIR_BIT];
    wire logic is_mem = (c_cls == cmv_pkg::CL_MEM);
    wire logic is_add = (c_op == cmv_pkg::OP_ADD) || (c_op == cmv_pkg::OP_ADD_CARRY_OP);

    // Instruction length
    wire logic is_rind = (c_mode <= cmv_pkg::M_PD);
    wire logic one_byte = (c_op == cmv_pkg::OP_MOVB) && (c_mode <= cmv_pkg::M_PB_DEC);
    wire logic [3:0] mem_len = is_rind ? (one_byte ? cmv_pkg::MLEN_RIND_SHORT : cmv_pkg::MLEN_RIND) :
                               (c_mode == cmv_pkg::M_BASED) ? cmv_pkg::MLEN_BASED :
                               (c_mode == cmv_pkg::M_INDEXED) ? cmv_pkg::MLEN_INDEXED :
                               cmv_pkg::MLEN_BIDX;
    wire logic long_form = ((c_cls == cmv_pkg::CL_SADDR) && (addr_r[15:8] == cmv_pkg::SADDR1_PAGE)) ||
                           ((c_cls == cmv_pkg::CL_REG) && addr_r[cmv_pkg::REG_UPPER_BIT]);
    wire logic [3:0] len_w = is_mem ? mem_len : ({1'b0, c_blen} + {3'h0, long_form});

    // Refused encodings
    wire logic post_inc = (c_mode == cmv_pkg::M_PA_INC) || (c_mode == cmv_pkg::M_PB_INC);
    wire logic post_dec = (c_mode == cmv_pkg::M_PA_DEC) || (c_mode == cmv_pkg::M_PB_DEC);
    wire logic bad_g = (c_op == cmv_pkg::OP_TRIPLE_MOVE_OP) && is_mem &&
                       ((c_mode == cmv_pkg::M_PB_INC) || (c_mode == cmv_pkg::M_PB_DEC));
    wire logic bad_br = ((c_op == cmv_pkg::OP_BR8) && (c_pfx != cmv_pkg::PX_REL8)) ||
                        ((c_op == cmv_pkg::OP_BR16) && (c_pfx != cmv_pkg::PX_REL16));
    wire logic ill_w = (c_op > cmv_pkg::OP_FLAGS) || (is_mem && (c_mode > cmv_pkg::M_BIDX)) ||
                       bad_g || bad_br;
    wire logic exec_ok = exec & ~ill_w;

    // Effective address and pointer post-update
    wire logic [1:0] p_idx = ptr_idx(c_mode, c_bsel);
    wire logic [23:0] p_val = ptr_r[p_idx];
    wire logic [23:0] step = (c_op == cmv_pkg::OP_TRIPLE_MOVE_OP) ? 24'h00_0003 :
                             ((c_op == cmv_pkg::OP_WORD_MOVE_OP) || (c_op == cmv_pkg::OP_WORD_SWAP_OP)) ? 24'h00_0002 :
                             24'h00_0001;
    wire logic [23:0] post_val = post_inc ? (p_val + step) : (p_val - step);
    wire logic post_en = exec_ok && is_mem && (post_inc || post_dec);
    wire logic ld_b = exec_ok && is_mem && (c_op == cmv_pkg::OP_TRIPLE_MOVE_OP) && !c_dir;
    wire logic [23:0] ea_w = !is_mem ? ((c_pfx == cmv_pkg::PX_ABS16) ? {8'h00, addr_r[15:0]} : addr_r) :
                             is_rind ? p_val :
                             (c_mode == cmv_pkg::M_BASED) ? (p_val + {16'h0000, addr_r[7:0]}) :
                             (c_mode == cmv_pkg::M_INDEXED) ? addr_r :
                             (p_val + {8'h00, addr_r[15:0]});

    // Branch targets
    wire logic [19:0] next_pc = pc_r + {16'h0000, len_w};
    wire logic [19:0] disp = (c_op == cmv_pkg::OP_BR8) ? {{12{opb_r[7]}}, opb_r[7:0]} :
                             {{4{opb_r[15]}}, opb_r[15:0]};
    wire logic [19:0] tgt_w = next_pc + disp;
    wire logic is_br = (c_op == cmv_pkg::OP_BR8) || (c_op == cmv_pkg::OP_BR16);

    // Byte adder
    wire logic add_cin = (c_op == cmv_pkg::OP_ADD_CARRY_OP) & psw_r[cmv_pkg::FB_CY];
    logic [7:0] a_sum;
    logic a_cy;
    logic a_ac;
    logic a_ov;
    cmv_add8 u_add (
        .a(opa_r[7:0]),
        .b(opb_r[7:0]),
        .cin(add_cin),
        .sum(a_sum),
        .cy(a_cy),
        .ac(a_ac),
        .ov(a_ov)
    );

    // Flag codes: add forms fixed, explicit flag op from register, others keep
    wire logic [14:0] fc = is_add ? {cmv_pkg::FC_RES, cmv_pkg::FC_RES, cmv_pkg::FC_RES,
                                     cmv_pkg::FC_OVF, cmv_pkg::FC_RES} :
                           (c_op == cmv_pkg::OP_FLAGS) ? fcode_r : 15'h0000;
    wire logic [7:0] f_byte = is_add ? a_sum : opa_r[7:0];
    wire logic r_ac = is_add ? a_ac : opb_r[cmv_pkg::FB_AC];
    wire logic r_cy = is_add ? a_cy : opb_r[cmv_pkg::FB_CY];
    wire logic r_ov = is_add ? a_ov : opb_r[cmv_pkg::FB_PV];
    wire logic r_pv = (fc[5:3] == cmv_pkg::FC_PAR) ? ~^f_byte : r_ov;
    logic [7:0] status_word_low_nxt;
    always_comb begin
        status_word_low_nxt = psw_r[7:0];
        if (c_op == cmv_pkg::OP_STATUS_WORD_LOW) begin
            status_word_low_nxt = {psw_r[cmv_pkg::FB_S], opb_r[6:0]};
        end else begin
            status_word_low_nxt[cmv_pkg::FB_S] = fl_apply(fc[14:12], psw_r[cmv_pkg::FB_S], f_byte[7], sav_r[cmv_pkg::FB_S]);
            status_word_low_nxt[cmv_pkg::FB_Z] = fl_apply(fc[11:9], psw_r[cmv_pkg::FB_Z], f_byte == 8'h00,
                                               sav_r[cmv_pkg::FB_Z]);
            status_word_low_nxt[cmv_pkg::FB_AC] = fl_apply(fc[8:6], psw_r[cmv_pkg::FB_AC], r_ac, sav_r[cmv_pkg::FB_AC]);
            status_word_low_nxt[cmv_pkg::FB_PV] = fl_apply(fc[5:3], psw_r[cmv_pkg::FB_PV], r_pv, sav_r[cmv_pkg::FB_PV]);
            status_word_low_nxt[cmv_pkg::FB_CY] = fl_apply(fc[2:0], psw_r[cmv_pkg::FB_CY], r_cy, sav_r[cmv_pkg::FB_CY]);
        end
    end
    wire logic [7:0] status_word_high_nxt = (c_op == cmv_pkg::OP_STATUS_WORD_HIGH) ? opb_r[7:0] : psw_r[15:8];

    // Operand results
    logic [23:0] res_a_nxt;
    logic [23:0] res_b_nxt;
    always_comb begin
        res_a_nxt = {16'h0000, opb_r[7:0]};
        res_b_nxt = opb_r;
        case (c_op)
            cmv_pkg::OP_XCHB: begin
                res_b_nxt = {16'h0000, opa_r[7:0]};
            end
            cmv_pkg::OP_WORD_MOVE_OP: begin
                res_a_nxt = {8'h00, opb_r[15:0]};
            end
            cmv_pkg::OP_WORD_SWAP_OP: begin
                res_a_nxt = {8'h00, opb_r[15:0]};
                res_b_nxt = {8'h00, opa_r[15:0]};
            end
            cmv_pkg::OP_TRIPLE_MOVE_OP: begin
                res_a_nxt = (is_mem && c_dir) ? ptr_r[1] : opb_r;
            end
            cmv_pkg::OP_ADD, cmv_pkg::OP_ADD_CARRY_OP: begin
                res_a_nxt = {16'h0000, a_sum};
            end
            cmv_pkg::OP_FLAGS: begin
                res_a_nxt = opa_r;
            end
            default: begin
                res_a_nxt = {16'h0000, opb_r[7:0]};
            end
        endcase
    end

    // Register read selection
    always_comb begin
        if (paddr == cmv_pkg::OFS_CTRL) begin
            rd_mux = ctrl_r;
        end else if (paddr == cmv_pkg::OFS_OPA) begin
            rd_mux = {8'h00, opa_r};
        end else if (paddr == cmv_pkg::OFS_OPB) begin
            rd_mux = {8'h00, opb_r};
        end else if (paddr == cmv_pkg::OFS_ADDR) begin
            rd_mux = {8'h00, addr_r};
        end else if (paddr == cmv_pkg::OFS_PSW) begin
            rd_mux = {16'h0000, psw_r};
        end else if (paddr == cmv_pkg::OFS_SAVED) begin
            rd_mux = {24'h00_0000, sav_r};
        end else if (paddr == cmv_pkg::OFS_FCODE) begin
            rd_mux = {17'h0_0000, fcode_r};
        end else if (paddr == cmv_pkg::OFS_PC) begin
            rd_mux = {12'h000, pc_r};
        end else if (paddr == cmv_pkg::OFS_RES_A) begin
            rd_mux = {8'h00, res_a_r};
        end else if (paddr == cmv_pkg::OFS_RES_B) begin
            rd_mux = {8'h00, res_b_r};
        end else if (paddr == cmv_pkg::OFS_TARGET) begin
            rd_mux = {12'h000, tgt_r};
        end else if (paddr == cmv_pkg::OFS_INFO) begin
            rd_mux = {23'h00_0000, info_r};
        end else if (hit) begin
            rd_mux = {8'h00, ptr_r[paddr[3:2]]};
        end else begin
            rd_mux = 32'h0000_0000;
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            setup_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
        end else if (ce) begin
            setup_r <= cap | (setup_r & ~(psel & penable));
            if (cap) begin
                prdata_r <= rd_mux;
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_r <= 32'h0000_0000;
            opa_r <= cmv_pkg::PTR_RST;
            opb_r <= cmv_pkg::PTR_RST;
            addr_r <= cmv_pkg::PTR_RST;
            sav_r <= 8'h00;
            fcode_r <= cmv_pkg::FCODE_RST;
        end else if (ce && wr && hit) begin
            if (paddr == cmv_pkg::OFS_CTRL) ctrl_r <= pwdata;
            if (paddr == cmv_pkg::OFS_OPA) opa_r <= pwdata[23:0];
            if (paddr == cmv_pkg::OFS_OPB) opb_r <= pwdata[23:0];
            if (paddr == cmv_pkg::OFS_ADDR) addr_r <= pwdata[23:0];
            if (paddr == cmv_pkg::OFS_SAVED) sav_r <= pwdata[7:0];
            if (paddr == cmv_pkg::OFS_FCODE) fcode_r <= pwdata[14:0];
        end
    end

    // Architectural state: executed writes and direct software writes
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            psw_r <= cmv_pkg::PSW_RST;
            pc_r <= cmv_pkg::PC_RST;
            res_a_r <= cmv_pkg::PTR_RST;
            res_b_r <= cmv_pkg::PTR_RST;
            tgt_r <= cmv_pkg::PC_RST;
            mem_addr_r <= cmv_pkg::PTR_RST;
        end else if (ce) begin
            if (exec_ok) begin
                psw_r <= {status_word_high_nxt, status_word_low_nxt};
                pc_r <= is_br ? tgt_w : next_pc;
                tgt_r <= tgt_w;
                res_a_r <= res_a_nxt;
                res_b_r <= res_b_nxt;
                mem_addr_r <= ea_w;
            end else if (wr && paddr == cmv_pkg::OFS_PSW) begin
                psw_r <= pwdata[15:0];
            end else if (wr && paddr == cmv_pkg::OFS_PC) begin
                pc_r <= pwdata[19:0];
            end
        end
    end

    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            done_r <= 1'b0;
            ill_r <= 1'b0;
            info_r <= 9'h000;
        end else if (ce) begin
            done_r <= exec;
            if (exec) begin
                ill_r <= ill_w;
                info_r <= {ill_w, c_pfx, len_w};
            end
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_ptr
            localparam logic [7:0] PTR_OFS = 8'(cmv_pkg::OFS_PTR0 + 4 * gi);
            always_ff @(posedge mclk or negedge rst_b) begin
                if (!rst_b) begin
                    ptr_r[gi] <= cmv_pkg::PTR_RST;
                end else if (ce) begin
                    if (ld_b && gi == 1) begin
                        ptr_r[gi] <= opb_r;
                    end else if (post_en && p_idx == 2'(gi)) begin
                        ptr_r[gi] <= post_val;
                    end else if (wr && paddr == PTR_OFS) begin
                        ptr_r[gi] <= pwdata[23:0];
                    end
                end
            end
        end
    endgenerate

    assign mem_addr = mem_addr_r;
    assign op_done = done_r;
    assign op_illegal = ill_r;

    // Checks
    add_flags_a: assert property (@(posedge mclk) disable iff (!rst_b)
        exec_ok && is_add |=> psw_r[cmv_pkg::FB_CY] == $past(a_cy) && psw_r[cmv_pkg::FB_PV] == $past(a_ov))
        else $error("add flags wrong");
    add_carry_op_sum_a: assert property (@(posedge mclk) disable iff (!rst_b)
        exec_ok && c_op == cmv_pkg::OP_ADD_CARRY_OP |=> res_a_r[7:0] == 8'($past(opa_r[7:0]) + $past(opb_r[7:0])
        + {7'h00, $past(psw_r[cmv_pkg::FB_CY])}))
        else $error("add with carry sum wrong");
    word_move_a: assert property (@(posedge mclk) disable iff (!rst_b)
        exec_ok && c_op == cmv_pkg::OP_WORD_MOVE_OP |=> $stable(psw_r) && res_a_r[15:0] == $past(opb_r[15:0]))
        else $error("word move changed flags");
    status_low_a: assert property (@(posedge mclk) disable iff (!rst_b)
        exec_ok && c_op == cmv_pkg::OP_STATUS_WORD_LOW |=> psw_r[7] == $past(psw_r[7]) && psw_r[6:0] == $past(opb_r[6:0]))
        else $error("status low load wrong");
    byte_swap_a: assert property (@(posedge mclk) disable iff (!rst_b)
        exec_ok && c_op == cmv_pkg::OP_XCHB |=> res_a_r[7:0] == $past(opb_r[7:0])
        && res_b_r[7:0] == $past(opa_r[7:0]) && $stable(psw_r))
        else $error("byte swap wrong");
    one_byte_a: assert property (@(posedge mclk) disable iff (!rst_b)
        exec && is_mem && len_w == 4'h1 |-> c_op == cmv_pkg::OP_MOVB && c_mode <= cmv_pkg::M_PB_DEC)
        else $error("one byte form misused");
    triple_post_a: assert property (@(posedge mclk) disable iff (!rst_b)
        exec && bad_g |=> op_illegal && op_done ##1 !op_done || exec)
        else $error("triple move post form accepted");
    short_branch_a: assert property (@(posedge mclk) disable iff (!rst_b)
        exec_ok && c_op == cmv_pkg::OP_BR8 |=> pc_r == 20'($past(next_pc) + {{12{$past(opb_r[7])}},
        $past(opb_r[7:0])}))
        else $error("short branch target wrong");
endmodule // cmv_exec_unit
`default_nettype wire

// ==== core/cmv_pkg.sv ====
`default_nettype none
package cmv_pkg;
    // Register byte offsets
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_OPA = 8'h04;
    localparam logic [7:0] OFS_OPB = 8'h08;
    localparam logic [7:0] OFS_ADDR = 8'h0C;
    localparam logic [7:0] OFS_PSW = 8'h10;
    localparam logic [7:0] OFS_SAVED = 8'h14;
    localparam logic [7:0] OFS_FCODE = 8'h18;
    localparam logic [7:0] OFS_PC = 8'h1C;
    localparam logic [7:0] OFS_RES_A = 8'h20;
    localparam logic [7:0] OFS_RES_B = 8'h24;
    localparam logic [7:0] OFS_TARGET = 8'h28;
    localparam logic [7:0] OFS_INFO = 8'h2C;
    localparam logic [7:0] OFS_PTR0 = 8'h30;
    localparam logic [7:0] OFS_PTR3 = 8'h3C;
    // Control word fields
    localparam int CF_OP_LSB = 0;
    localparam int CF_MODE_LSB = 4;
    localparam int CF_CLASS_LSB = 8;
    localparam int CF_PREFIX_LSB = 12;
    localparam int CF_BLEN_LSB = 16;
    localparam int CF_BSEL_LSB = 20;
    localparam int CF_DIR_BIT = 24;
    // Status byte flag positions
    localparam int FB_S = 7;
    localparam int FB_Z = 6;
    localparam int FB_AC = 4;
    localparam int FB_PV = 2;
    localparam int FB_CY = 0;
    localparam int REG_UPPER_BIT = 3;
    // Reset values
    localparam logic [15:0] PSW_RST = 16'h0000;
    localparam logic [23:0] PTR_RST = 24'h00_0000;
    localparam logic [14:0] FCODE_RST = 15'h0000;
    localparam logic [19:0] PC_RST = 20'h0_0000;
    // Memory operand lengths in bytes
    localparam logic [3:0] MLEN_RIND_SHORT = 4'h1;
    localparam logic [3:0] MLEN_RIND = 4'h2;
    localparam logic [3:0] MLEN_BASED = 4'h3;
    localparam logic [3:0] MLEN_INDEXED = 4'h5;
    localparam logic [3:0] MLEN_BIDX = 4'h2;
    localparam logic [7:0] SADDR1_PAGE = 8'hFE;

    typedef enum logic [3:0] {
        OP_MOVB = 4'h0, OP_WORD_MOVE_OP = 4'h1, OP_TRIPLE_MOVE_OP = 4'h2, OP_XCHB = 4'h3,
        OP_WORD_SWAP_OP = 4'h4, OP_ADD = 4'h5, OP_ADD_CARRY_OP = 4'h6, OP_STATUS_WORD_LOW = 4'h7,
        OP_STATUS_WORD_HIGH = 4'h8, OP_BR8 = 4'h9, OP_BR16 = 4'hA, OP_FLAGS = 4'hB
    } cmv_op_t;

    typedef enum logic [3:0] {
        M_PA = 4'h0, M_PB = 4'h1, M_PA_INC = 4'h2, M_PB_INC = 4'h3,
        M_PA_DEC = 4'h4, M_PB_DEC = 4'h5, M_PC = 4'h6, M_PD = 4'h7,
        M_BASED = 4'h8, M_INDEXED = 4'h9, M_BIDX = 4'hA
    } cmv_mode_t;

    typedef enum logic [1:0] {
        CL_NONE = 2'h0, CL_MEM = 2'h1, CL_SADDR = 2'h2, CL_REG = 2'h3
    } cmv_class_t;

    typedef enum logic [3:0] {
        PX_NONE = 4'h0, PX_IMM = 4'h1, PX_ABS16 = 4'h2, PX_ABS24 = 4'h3,
        PX_REL8 = 4'h4, PX_REL16 = 4'h5, PX_BITINV = 4'h6, PX_IND = 4'h7,
        PX_IND24 = 4'h8
    } cmv_prefix_t;

    typedef enum logic [2:0] {
        FC_KEEP = 3'h0, FC_CLR = 3'h1, FC_SET = 3'h2, FC_RES = 3'h3,
        FC_PAR = 3'h4, FC_OVF = 3'h5, FC_REST = 3'h6
    } cmv_fcode_t;
endpackage
`default_nettype wire

// ==== testbench/test_cpu_move_add_instructions.sv ====
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, g) begin checks_done++; if ((g) !== (e)) begin failures++; $display("CHECK FAILED %s exp %h got %h", n, e, g); end end
module test_cpu_move_add_instructions;
    logic mclk = 1'b0, rst_b = 1'b0, ce = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, rd;
    logic pready, pslverr, op_done, op_illegal, err;
    logic [23:0] mem_addr;
    int failures = 0, checks_done = 0;
    logic [31:0] ctl [6] = '{32'h0000_0105, 32'h0000_0185, 32'h0000_0195, 32'h0000_01A5, 32'h0000_0100, 32'h0000_0120};
    logic [3:0] len [6] = '{4'h2, 4'h3, 4'h5, 4'h2, 4'h1, 4'h1};
    always #5 mclk = ~mclk;
    cmv_exec_unit dut_u (.mclk(mclk), .rst_b(rst_b), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .mem_addr(mem_addr), .op_done(op_done), .op_illegal(op_illegal));
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge mclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk);
        penable <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        if (n == 20) failures++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input string s, input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0000_0000);
        `CHK(s, e, rd)
    endtask
    task automatic op(input logic [31:0] c);
        int n;
        n = 0;
        xfer(1'b1, cmv_pkg::OFS_CTRL, c);
        while (op_done !== 1'b1 && n < 3) begin
            @(posedge mclk);
            n++;
        end
        `CHK("op_done", 1'b1, op_done)
    endtask
    task automatic t_add();
        rdchk("psw_reset", cmv_pkg::OFS_PSW, 32'h0000_0000);
        xfer(1'b1, cmv_pkg::OFS_OPA, 32'h0000_007F);
        xfer(1'b1, cmv_pkg::OFS_OPB, 32'h0000_0001);
        op(32'h0000_0005);
        rdchk("add_sum", cmv_pkg::OFS_RES_A, 32'h0000_0080);
        rdchk("add_flags", cmv_pkg::OFS_PSW, 32'h0000_0094);
        xfer(1'b1, cmv_pkg::OFS_PSW, 32'h0000_0001);
        xfer(1'b1, cmv_pkg::OFS_OPA, 32'h0000_00FF);
        xfer(1'b1, cmv_pkg::OFS_OPB, 32'h0000_0000);
        op(32'h0000_0006);
        rdchk("add_carry_op_sum", cmv_pkg::OFS_RES_A, 32'h0000_0000);
        rdchk("add_carry_op_flags", cmv_pkg::OFS_PSW, 32'h0000_0051);
        $display("test add done");
    endtask
    task automatic t_moves();
        for (int i = 0; i < 5; i++) begin
            op(i);
            rdchk("move_flags", cmv_pkg::OFS_PSW, 32'h0000_0051);
        end
        xfer(1'b1, cmv_pkg::OFS_OPB, 32'h0000_00FF);
        op(32'h0000_0007);
        xfer(1'b0, cmv_pkg::OFS_PSW, 32'h0000_0000);
        `CHK("status_low", 8'h7F, rd[7:0])
        $display("test moves done");
    endtask
    task automatic t_branch();
        xfer(1'b1, cmv_pkg::OFS_PC, 32'h0000_0100);
        xfer(1'b1, cmv_pkg::OFS_OPB, 32'h0000_0080);
        op(32'h0002_4009);
        xfer(1'b0, cmv_pkg::OFS_TARGET, 32'h0000_0000);
        `CHK("short_target", 20'h0_0082, rd[19:0])
        xfer(1'b1, cmv_pkg::OFS_PC, 32'h0001_0000);
        xfer(1'b1, cmv_pkg::OFS_OPB, 32'h0000_8000);
        op(32'h0003_500A);
        xfer(1'b0, cmv_pkg::OFS_TARGET, 32'h0000_0000);
        `CHK("long_target", 20'h0_8003, rd[19:0])
        $display("test branch done");
    endtask
    task automatic t_len();
        for (int i = 0; i < 6; i++) begin
            op(ctl[i]);
            xfer(1'b0, cmv_pkg::OFS_INFO, 32'h0000_0000);
            `CHK("mem_length", len[i], rd[3:0])
        end
        $display("test length done");
    endtask
    task automatic t_refuse();
        op(32'h0000_0132);
        `CHK("triple_refused", 1'b1, op_illegal)
        op(32'h0000_0009);
        `CHK("prefix_refused", 1'b1, op_illegal)
        op(32'h0002_4009);
        `CHK("prefix_taken", 1'b0, op_illegal)
        xfer(1'b1, 8'h40, 32'h0000_0001);
        `CHK("unmapped", 1'b1, err)
        $display("test refuse done");
    endtask
    task automatic t_addr();
        xfer(1'b1, cmv_pkg::OFS_PTR0, 32'h0012_3456);
        op(32'h0000_0120);
        `CHK("ptr_addr", 24'h12_3456, mem_addr)
        rdchk("post_inc", cmv_pkg::OFS_PTR0, 32'h0012_3457);
        xfer(1'b1, cmv_pkg::OFS_OPB, 32'h00AB_CDEF);
        op(32'h0000_0112);
        rdchk("triple_load", cmv_pkg::OFS_PTR0 + 8'h04, 32'h00AB_CDEF);
        xfer(1'b1, cmv_pkg::OFS_ADDR, 32'h0000_FE20);
        op(32'h0003_0200);
        xfer(1'b0, cmv_pkg::OFS_INFO, 32'h0000_0000);
        `CHK("long_form", 4'h4, rd[3:0])
        xfer(1'b1, cmv_pkg::OFS_ADDR, 32'h0000_FD20);
        op(32'h0003_0200);
        xfer(1'b0, cmv_pkg::OFS_INFO, 32'h0000_0000);
        `CHK("short_form", 4'h3, rd[3:0])
        $display("test address done");
    endtask
    task automatic t_flags();
        xfer(1'b1, cmv_pkg::OFS_PSW, 32'h0000_0090);
        xfer(1'b1, cmv_pkg::OFS_SAVED, 32'h0000_0001);
        xfer(1'b1, cmv_pkg::OFS_FCODE, 32'h0000_0466);
        xfer(1'b1, cmv_pkg::OFS_OPA, 32'h0000_0003);
        op(32'h0000_000B);
        rdchk("flag_codes", cmv_pkg::OFS_PSW, 32'h0000_00C5);
        xfer(1'b1, cmv_pkg::OFS_OPB, 32'h0000_005A);
        op(32'h0000_0008);
        rdchk("status_high", cmv_pkg::OFS_PSW, 32'h0000_5AC5);
        xfer(1'b1, cmv_pkg::OFS_OPA, 32'h0000_1234);
        xfer(1'b1, cmv_pkg::OFS_OPB, 32'h0000_ABCD);
        op(32'h0000_0004);
        rdchk("word_swap_a", cmv_pkg::OFS_RES_A, 32'h0000_ABCD);
        rdchk("word_swap_b", cmv_pkg::OFS_RES_B, 32'h0000_1234);
        $display("test flags done");
    endtask
    task automatic t_freeze();
        int n;
        n = 0;
        @(posedge mclk);
        ce <= 1'b0;
        psel <= 1'b1;
        pwrite <= 1'b1;
        paddr <= cmv_pkg::OFS_OPA;
        pwdata <= 32'h0000_0055;
        @(posedge mclk);
        penable <= 1'b1;
        repeat (2) @(posedge mclk);
        `CHK("frozen_ready", 1'b0, pready)
        ce <= 1'b1;
        @(posedge mclk);
        while (pready !== 1'b1 && n < 20) begin
            @(posedge mclk);
            n++;
        end
        if (n == 20) failures++;
        psel <= 1'b0;
        penable <= 1'b0;
        rdchk("thawed_write", cmv_pkg::OFS_OPA, 32'h0000_0055);
        $display("test freeze done");
    endtask
    task automatic conclude();
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        t_add();
        t_moves();
        t_branch();
        t_len();
        t_refuse();
        t_addr();
        t_flags();
        t_freeze();
        conclude();
    end
    initial begin
        #100000;
        failures++;
        conclude();
    end
endmodule // test_cpu_move_add_instructions
`default_nettype wire
